// >>> rtl/sbpsf_top.sv
// Purpose: Device command-state machine: power states plus eight banks.
// Assumes: Controller drives decoded commands synchronous to core_clk.
// Notes: Clock gate and chip select are pins and pass four flip-flops.
`timescale 1ns/100ps
module sbpsf_top #(
  parameter int INIT_CYCLES = sbpsf_pkg::INIT_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkGate,
  input wire logic chipSel_n,
  input wire logic [3:0] cmdCode,
  input wire logic [2:0] cmdBank,
  output logic [3:0] devState,
  output logic [23:0] bankStates,
  output logic anyBankActive,
  output logic exitWait,
  output logic modeWriteLoad,
  output logic modeReadReturn
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  // Three-stage chains for clock gate and chip select.
  logic [2:0] gateSync_r;
  logic [2:0] csSync_r;
  // Filtered levels: update only when stages two and three agree.
  logic gateNow_r;
  logic gatePrev_r;
  logic csNow_r;
  logic sampleValid_r;
  // Command delayed four cycles, as deep as the filtered pins.
  logic [1:0][3:0] cmdPre_r;
  logic [1:0][2:0] bankPre_r;
  logic [3:0] cmdDly1_r, cmdDly2_r;
  logic [2:0] bankDly1_r, bankDly2_r;

  // Shift the pin chains; stage 0 is read only by stage 1.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gateSync_r <= 3'h0;
      csSync_r <= 3'h7;
    end else begin
      gateSync_r <= {gateSync_r[1:0], clkGate};
      csSync_r <= {csSync_r[1:0], chipSel_n};
    end
  end

  // Filter and keep the previous gate sample for the edge compare.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gateNow_r <= 1'b0;
      gatePrev_r <= 1'b0;
      csNow_r <= 1'b1;
      sampleValid_r <= 1'b0;
    end else begin
      if (gateSync_r[1] == gateSync_r[2]) begin
        gateNow_r <= gateSync_r[2];
      end
      if (csSync_r[1] == csSync_r[2]) begin
        csNow_r <= csSync_r[2];
      end
      gatePrev_r <= gateNow_r;
      sampleValid_r <= 1'b1;
    end
  end

  // Delay the command by the same depth as the filtered pins.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmdPre_r <= '0;
      bankPre_r <= '0;
      cmdDly1_r <= sbpsf_pkg::CMD_NOP;
      cmdDly2_r <= sbpsf_pkg::CMD_NOP;
      bankDly1_r <= 3'h0;
      bankDly2_r <= 3'h0;
    end else begin
      cmdPre_r <= {cmdPre_r[0], cmdCode};
      cmdDly1_r <= cmdPre_r[1];
      cmdDly2_r <= cmdDly1_r;
      bankPre_r <= {bankPre_r[0], cmdBank};
      bankDly1_r <= bankPre_r[1];
      bankDly2_r <= bankDly1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge classification.
  // Gate high on both edges: ordinary commands are accepted.
  logic gateHH;
  logic gateHL;
  logic gateLH;
  logic cmdSel;
  assign gateHH = sampleValid_r && gatePrev_r && gateNow_r;
  assign gateHL = sampleValid_r && gatePrev_r && !gateNow_r;
  assign gateLH = sampleValid_r && !gatePrev_r && gateNow_r;
  assign cmdSel = !csNow_r;

  ////////////////////////////////////////////////////////////////////////
  // Device state and its timers.
  sbpsf_pkg::sbpsf_dev_e dev_r;
  sbpsf_pkg::sbpsf_dev_e modeReadRet_r;
  logic [sbpsf_pkg::TMR_W-1:0] devTimer_r;
  logic [sbpsf_pkg::TMR_W-1:0] initTimer_r;
  logic [sbpsf_pkg::TMR_W-1:0] exitTimer_r;
  logic [2:0] bankSt [sbpsf_pkg::NUM_BANKS];
  logic allIdle;
  logic anyActive;
  logic bankBusy;

  // True when a bank state equals the wanted one.
  function automatic logic bank_is(input logic [2:0] st,
                                   input logic [2:0] want);
    bank_is = (st == want);
  endfunction

  // Summaries of the bank states used by power-state decisions.
  always_comb begin
    allIdle = 1'b1;
    anyActive = 1'b0;
    bankBusy = 1'b0;
    for (int i = 0; i < sbpsf_pkg::NUM_BANKS; i++) begin
      if (!bank_is(bankSt[i], sbpsf_pkg::BK_IDLE)) begin
        allIdle = 1'b0;
      end
      if (bank_is(bankSt[i], sbpsf_pkg::BK_ACTIVE)) begin
        anyActive = 1'b1;
      end
      if (!bank_is(bankSt[i], sbpsf_pkg::BK_IDLE) &&
          !bank_is(bankSt[i], sbpsf_pkg::BK_ACTIVE)) begin
        bankBusy = 1'b1;
      end
    end
  end

  // Commands need the gate high twice and no exit wait.
  logic devReady;
  assign devReady = gateHH && cmdSel && exitTimer_r == '0;

  // Power state machine.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dev_r <= sbpsf_pkg::DEV_POWER_ON;
      modeReadRet_r <= sbpsf_pkg::DEV_NORMAL;
      devTimer_r <= '0;
    end else begin
      case (dev_r)
        sbpsf_pkg::DEV_POWER_ON: begin
          if (devReady && cmdDly2_r == sbpsf_pkg::CMD_RESET) begin
            dev_r <= sbpsf_pkg::DEV_RESETTING;
          end
        end
        sbpsf_pkg::DEV_RESETTING: begin
          if (gateHL && !cmdSel) begin
            dev_r <= sbpsf_pkg::DEV_RESET_PD;
          end else if (initTimer_r == '0) begin
            dev_r <= sbpsf_pkg::DEV_NORMAL;
          end else if (devReady &&
                       cmdDly2_r == sbpsf_pkg::CMD_MODE_READ) begin
            dev_r <= sbpsf_pkg::DEV_MODE_READING;
            modeReadRet_r <= sbpsf_pkg::DEV_RESETTING;
            devTimer_r <= sbpsf_pkg::TMR_W'(sbpsf_pkg::MRR_CYC);
          end
        end
        sbpsf_pkg::DEV_NORMAL: begin
          if (gateHL && !cmdSel) begin
            // Clock-gate falls with chip select high.
            if (anyActive) begin
              dev_r <= sbpsf_pkg::DEV_ACTIVE_PD;
            end else if (allIdle) begin
              dev_r <= sbpsf_pkg::DEV_IDLE_PD;
            end
          end else if (gateHL && cmdSel && allIdle) begin
            if (cmdDly2_r == sbpsf_pkg::CMD_SELF_REFRESH) begin
              dev_r <= sbpsf_pkg::DEV_SELF_REFRESH;
            end else if (cmdDly2_r == sbpsf_pkg::CMD_DEEP_PD) begin
              dev_r <= sbpsf_pkg::DEV_DEEP_PD;
            end
          end else if (devReady && allIdle) begin
            case (cmdDly2_r)
              sbpsf_pkg::CMD_MODE_WRITE: begin
                dev_r <= sbpsf_pkg::DEV_MODE_WRITING;
                devTimer_r <= sbpsf_pkg::TMR_W'(sbpsf_pkg::MRW_CYC);
              end
              sbpsf_pkg::CMD_REFRESH_ALL: begin
                dev_r <= sbpsf_pkg::DEV_REFRESH_ALL;
                devTimer_r <= sbpsf_pkg::TMR_W'(sbpsf_pkg::RFCAB_CYC);
              end
              sbpsf_pkg::CMD_RESET: begin
                dev_r <= sbpsf_pkg::DEV_RESETTING;
              end
              sbpsf_pkg::CMD_MODE_READ: begin
                dev_r <= sbpsf_pkg::DEV_MODE_READING;
                modeReadRet_r <= sbpsf_pkg::DEV_NORMAL;
                devTimer_r <= sbpsf_pkg::TMR_W'(sbpsf_pkg::MRR_CYC);
              end
              default: begin
                dev_r <= dev_r;
              end
            endcase
          end else if (devReady && !bankBusy && anyActive &&
                       cmdDly2_r == sbpsf_pkg::CMD_MODE_READ) begin
            // Active mode read returns to the normal state, rows still open.
            dev_r <= sbpsf_pkg::DEV_MODE_READING;
            modeReadRet_r <= sbpsf_pkg::DEV_NORMAL;
            devTimer_r <= sbpsf_pkg::TMR_W'(sbpsf_pkg::MRR_CYC);
          end
        end
        sbpsf_pkg::DEV_IDLE_PD, sbpsf_pkg::DEV_ACTIVE_PD: begin
          // Gate low on both edges keeps the state.
          if (gateLH && !cmdSel) begin
            dev_r <= sbpsf_pkg::DEV_NORMAL;
          end
        end
        sbpsf_pkg::DEV_RESET_PD: begin
          if (gateLH && !cmdSel) begin
            if (initTimer_r == '0) begin
              dev_r <= sbpsf_pkg::DEV_NORMAL;
            end else begin
              dev_r <= sbpsf_pkg::DEV_RESETTING;
            end
          end
        end
        sbpsf_pkg::DEV_SELF_REFRESH: begin
          if (gateLH && !cmdSel) begin
            dev_r <= sbpsf_pkg::DEV_NORMAL;
          end
        end
        sbpsf_pkg::DEV_DEEP_PD: begin
          if (gateLH && !cmdSel) begin
            dev_r <= sbpsf_pkg::DEV_POWER_ON;
          end
        end
        sbpsf_pkg::DEV_MODE_WRITING, sbpsf_pkg::DEV_MODE_READING,
        sbpsf_pkg::DEV_REFRESH_ALL: begin
          // Timed device states end when their counter expires.
          if (devTimer_r <= 1) begin
            devTimer_r <= '0;
            dev_r <= (dev_r == sbpsf_pkg::DEV_MODE_READING) ?
                     modeReadRet_r : sbpsf_pkg::DEV_NORMAL;
          end else begin
            devTimer_r <= devTimer_r - 1'b1;
          end
        end
        default: begin
          dev_r <= sbpsf_pkg::DEV_POWER_ON;
        end
      endcase
    end
  end

  // Final initialization interval runs while resetting.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      initTimer_r <= '0;
    end else if (dev_r != sbpsf_pkg::DEV_RESETTING &&
                 dev_r != sbpsf_pkg::DEV_RESET_PD &&
                 dev_r != sbpsf_pkg::DEV_MODE_READING) begin
      initTimer_r <= sbpsf_pkg::TMR_W'(INIT_CYCLES);
    end else if (initTimer_r != '0) begin
      initTimer_r <= initTimer_r - 1'b1;
    end
  end

  // Exit wait after power-down or self refresh; only no-ops and self-refresh or deep power-down entry pass.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      exitTimer_r <= '0;
    end else if (gateLH && !cmdSel &&
                 dev_r == sbpsf_pkg::DEV_SELF_REFRESH) begin
      exitTimer_r <= sbpsf_pkg::TMR_W'(sbpsf_pkg::RFCAB_CYC);
    end else if (gateLH && !cmdSel) begin
      exitTimer_r <= sbpsf_pkg::TMR_W'(2);
    end else if (exitTimer_r != '0) begin
      exitTimer_r <= exitTimer_r - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Banks.
  // Bank commands need the normal state and an addressed bank.
  logic [sbpsf_pkg::NUM_BANKS-1:0] bankHit;
  always_comb begin
    for (int i = 0; i < sbpsf_pkg::NUM_BANKS; i++) begin
      bankHit[i] = devReady && dev_r == sbpsf_pkg::DEV_NORMAL &&
        (bankDly2_r == 3'(i) ||
         cmdDly2_r == sbpsf_pkg::CMD_PRECHARGE_ALL);
    end
  end

  // Precharge-all is presented to each bank as a precharge.
  logic [3:0] bankCmd;
  assign bankCmd = (cmdDly2_r == sbpsf_pkg::CMD_PRECHARGE_ALL) ?
                   sbpsf_pkg::CMD_PRECHARGE : cmdDly2_r;

  for (genvar g = 0; g < sbpsf_pkg::NUM_BANKS; g++) begin : gBank
    sbpsf_bank uBank (
      .core_clk(core_clk),
      .rst(rst),
      .cmdValid(bankHit[g]),
      .cmdCode(bankCmd),
      .bankState(bankSt[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      devState <= 4'h0;
      bankStates <= 24'h0;
      anyBankActive <= 1'b0;
      exitWait <= 1'b0;
      modeWriteLoad <= 1'b0;
      modeReadReturn <= 1'b0;
    end else begin
      devState <= dev_r;
      for (int i = 0; i < sbpsf_pkg::NUM_BANKS; i++) begin
        bankStates[i*3 +: 3] <= bankSt[i];
      end
      anyBankActive <= anyActive;
      exitWait <= exitTimer_r != '0;
      modeWriteLoad <= dev_r == sbpsf_pkg::DEV_NORMAL && devReady &&
        allIdle && cmdDly2_r == sbpsf_pkg::CMD_MODE_WRITE;
      modeReadReturn <= devReady && cmdDly2_r == sbpsf_pkg::CMD_MODE_READ &&
        (dev_r == sbpsf_pkg::DEV_NORMAL ||
         dev_r == sbpsf_pkg::DEV_RESETTING);
    end
  end
endmodule

// >>> rtl/sbpsf_pkg.sv
// Purpose: Shared constants and types for the bank and power state machine.
// Assumes: One clock, core_clk at 100 MHz.
// Notes: Timing figures are in ns; cycle counts derive from them.
//
// Contract
// - Sample clock gate each edge, compare previous.
// - Gate low twice holds low-power state.
// - Falling gate, select high enters power-down.
// - Falling gate with command enters self-refresh/deep.
// - Rising gate leaves deep power-down to power-on.
// - Rising gate leaves self refresh to idle.
// - Bank commands need gate high; exit wait.
// - Resetting power-down exit depends on init interval.
// - Activate opens row after row-to-column delay.
// - Precharge closes rows after precharge period.
// - Mode write from idle enters writing state.
// - Mode read enters matching reading state.
// - Reset command starts initialization, enters resetting.
// - Read on active row starts read burst.
// - Write on active row starts write burst.
// - Reading accepts read again, write switches.
// - Writing accepts write again, read switches.
// - Burst terminate ends read, bank active.
// - Burst terminate ends write, bank active.
// - Active means open row, delay met, idle.
// - Per-bank refresh holds bank for cycle time.
// - All-bank refresh holds device for cycle time.
// - Mode writing lasts the mode write time.
// - Mode reading lasts the mode read time.
package sbpsf_pkg;
  // Clock period in ps.
  localparam int CLK_PERIOD_PS = 10000;
  // Timing figures in ns (plain defaults).
  localparam int ROW_TO_COLUMN_DELAY_NS = 18;
  localparam int PRECHARGE_PERIOD_NS = 18;
  localparam int PER_BANK_REFRESH_CYCLE_TIME_NS = 60;
  localparam int ALL_BANK_REFRESH_CYCLE_TIME_NS = 130;
  localparam int MODE_WRITE_TIME_NS = 50;
  localparam int MODE_READ_TIME_NS = 20;
  localparam int FINAL_INIT_INTERVAL_NS = 10000;
  // Round a time in ns up to whole clock cycles.
  function automatic int ns_to_cyc(input int ns);
    return (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction
  localparam int RCD_CYC = ns_to_cyc(ROW_TO_COLUMN_DELAY_NS);
  localparam int RP_CYC = ns_to_cyc(PRECHARGE_PERIOD_NS);
  localparam int RFCPB_CYC = ns_to_cyc(PER_BANK_REFRESH_CYCLE_TIME_NS);
  localparam int RFCAB_CYC = ns_to_cyc(ALL_BANK_REFRESH_CYCLE_TIME_NS);
  localparam int MRW_CYC = ns_to_cyc(MODE_WRITE_TIME_NS);
  localparam int MRR_CYC = ns_to_cyc(MODE_READ_TIME_NS);
  localparam int INIT_CYC = ns_to_cyc(FINAL_INIT_INTERVAL_NS);
  // Width of the cycle counters.
  localparam int TMR_W = 16;
  // Number of banks.
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  // Decoded command codes on the cmdCode input.
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_ACTIVATE = 4'h1;
  localparam logic [3:0] CMD_READ = 4'h2;
  localparam logic [3:0] CMD_WRITE = 4'h3;
  localparam logic [3:0] CMD_PRECHARGE = 4'h4;
  localparam logic [3:0] CMD_PRECHARGE_ALL = 4'h5;
  localparam logic [3:0] CMD_REFRESH_BANK = 4'h6;
  localparam logic [3:0] CMD_REFRESH_ALL = 4'h7;
  localparam logic [3:0] CMD_MODE_WRITE = 4'h8;
  localparam logic [3:0] CMD_MODE_READ = 4'h9;
  localparam logic [3:0] CMD_RESET = 4'ha;
  localparam logic [3:0] CMD_BURST_TERM = 4'hb;
  localparam logic [3:0] CMD_SELF_REFRESH = 4'hc;
  localparam logic [3:0] CMD_DEEP_PD = 4'hd;
  // Device-level states.
  typedef enum logic [3:0] {
    DEV_POWER_ON, DEV_RESETTING, DEV_NORMAL, DEV_IDLE_PD, DEV_ACTIVE_PD,
    DEV_RESET_PD, DEV_SELF_REFRESH, DEV_DEEP_PD, DEV_MODE_WRITING,
    DEV_MODE_READING, DEV_REFRESH_ALL
  } sbpsf_dev_e;
  // Per-bank states.
  typedef enum logic [2:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READING, BK_WRITING,
    BK_PRECHARGING, BK_REFRESHING
  } sbpsf_bank_e;
endpackage

// >>> rtl/sbpsf_bank.sv
// Purpose: One bank's state machine with its own timing counter.
// Assumes: Commands arrive decoded and already qualified by the gate.
// Notes: A busy bank ignores commands addressed to it.
`timescale 1ns/100ps
module sbpsf_bank (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic [3:0] cmdCode,
  output logic [2:0] bankState
);
  // Current state and countdown to the end of a timed state.
  sbpsf_pkg::sbpsf_bank_e state_r;
  logic [sbpsf_pkg::TMR_W-1:0] timer_r;

  assign bankState = state_r;

  ////////////////////////////////////////////////////////////////////////
  // Next state: commands and expiry of the timed states.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= sbpsf_pkg::BK_IDLE;
      timer_r <= '0;
    end else if (timer_r != '0) begin
      // Timed state in progress; a no-op changes nothing here.
      timer_r <= timer_r - 1'b1;
      if (timer_r == 1) begin
        if (state_r == sbpsf_pkg::BK_ACTIVATING) begin
          state_r <= sbpsf_pkg::BK_ACTIVE;
        end else begin
          state_r <= sbpsf_pkg::BK_IDLE;
        end
      end
    end else if (cmdValid) begin
      case (state_r)
        sbpsf_pkg::BK_IDLE: begin
          if (cmdCode == sbpsf_pkg::CMD_ACTIVATE) begin
            state_r <= sbpsf_pkg::BK_ACTIVATING;
            timer_r <= sbpsf_pkg::TMR_W'(sbpsf_pkg::RCD_CYC);
          end else if (cmdCode == sbpsf_pkg::CMD_REFRESH_BANK) begin
            state_r <= sbpsf_pkg::BK_REFRESHING;
            timer_r <= sbpsf_pkg::TMR_W'(sbpsf_pkg::RFCPB_CYC);
          end else if (cmdCode == sbpsf_pkg::CMD_PRECHARGE) begin
            // Precharging an idle bank still takes the full period.
            state_r <= sbpsf_pkg::BK_PRECHARGING;
            timer_r <= sbpsf_pkg::TMR_W'(sbpsf_pkg::RP_CYC);
          end
        end
        sbpsf_pkg::BK_ACTIVE, sbpsf_pkg::BK_READING,
        sbpsf_pkg::BK_WRITING: begin
          if (cmdCode == sbpsf_pkg::CMD_READ) begin
            state_r <= sbpsf_pkg::BK_READING;
          end else if (cmdCode == sbpsf_pkg::CMD_WRITE) begin
            state_r <= sbpsf_pkg::BK_WRITING;
          end else if (cmdCode == sbpsf_pkg::CMD_BURST_TERM &&
                       state_r != sbpsf_pkg::BK_ACTIVE) begin
            state_r <= sbpsf_pkg::BK_ACTIVE;
          end else if (cmdCode == sbpsf_pkg::CMD_PRECHARGE) begin
            state_r <= sbpsf_pkg::BK_PRECHARGING;
            timer_r <= sbpsf_pkg::TMR_W'(sbpsf_pkg::RP_CYC);
          end
        end
        default: begin
          // Timed states never reach here with a zero timer.
          state_r <= state_r;
        end
      endcase
    end
  end
endmodule

// >>> tb/sbpsf_sva.sv
// Purpose: Port assertions for the bank and power state machine.
// Assumes: Bound to the top module's ports.
// Notes: Bank 3 is the bank watched in detail.
`timescale 1ns/100ps
module sbpsf_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkGate,
  input wire logic [3:0] devState,
  input wire logic [23:0] bankStates,
  input wire logic anyBankActive,
  input wire logic exitWait,
  input wire logic modeWriteLoad,
  input wire logic modeReadReturn
);
  logic [2:0] bk; // State of the watched bank.
  logic anyAct; // Some bank shows an open row.
  logic lowPwr; // Device sits in a clock-gated state.
  assign bk = bankStates[11:9];
  // Fold the bank vector into one active flag.
  always_comb begin
    anyAct = 1'b0;
    for (int i = 0; i < 8; i++) begin
      anyAct |= bankStates[3*i +: 3] == sbpsf_pkg::BK_ACTIVE;
    end
  end
  assign lowPwr = devState inside {sbpsf_pkg::DEV_IDLE_PD,
    sbpsf_pkg::DEV_ACTIVE_PD, sbpsf_pkg::DEV_RESET_PD,
    sbpsf_pkg::DEV_SELF_REFRESH, sbpsf_pkg::DEV_DEEP_PD};
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_flag_tracks_banks: assert property (anyAct == $past(anyAct) |->
    anyBankActive == anyAct) else $error("active flag wrong");
  a_gated_state_holds: assert property ((!clkGate)[*8] ##0 lowPwr
    |=> $stable(devState)) else $error("gated state moved");
  a_pd_bank_match: assert property (lowPwr |->
    (bankStates != 24'h0) == (devState == sbpsf_pkg::DEV_ACTIVE_PD))
    else $error("power-down kind wrong");
  a_deep_exit_dest: assert property (
    $past(devState) == sbpsf_pkg::DEV_DEEP_PD && lowPwr == 1'b0 |->
    devState == sbpsf_pkg::DEV_POWER_ON) else $error("deep exit wrong");
  a_sref_exit_dest: assert property (
    $past(devState) == sbpsf_pkg::DEV_SELF_REFRESH && !lowPwr |->
    devState == sbpsf_pkg::DEV_NORMAL) else $error("sref exit wrong");
  a_exit_wait_runs: assert property ($past(devState) inside
    {sbpsf_pkg::DEV_ACTIVE_PD, sbpsf_pkg::DEV_SELF_REFRESH} && !lowPwr
    |-> $past(exitWait) or ##[0:3] exitWait) else $error("no exit wait");
  a_row_open_delay: assert property ($past(bk) != 3'h1 &&
    bk == sbpsf_pkg::BK_ACTIVATING |=> bk == sbpsf_pkg::BK_ACTIVATING
    ##[1:3] bk == sbpsf_pkg::BK_ACTIVE) else $error("activation wrong");
  a_row_close_idle: assert property (
    $past(bk) == sbpsf_pkg::BK_PRECHARGING && bk != 3'h5 |->
    bk == sbpsf_pkg::BK_IDLE) else $error("precharge end wrong");
  a_refresh_len: assert property ($past(bk) != 3'h6 &&
    bk == sbpsf_pkg::BK_REFRESHING |-> (bk == 3'h6)[*5] ##[1:6]
    bk == sbpsf_pkg::BK_IDLE) else $error("bank refresh length wrong");
  a_write_load: assert property (modeWriteLoad |-> ##[0:3]
    devState == sbpsf_pkg::DEV_MODE_WRITING) else $error("load no state");
  a_pulse_len: assert property (modeWriteLoad || modeReadReturn |=>
    !modeWriteLoad && !modeReadReturn) else $error("strobe too long");
  a_mode_write_len: assert property (
    $past(devState) != 4'h8 && devState == 4'h8 |-> (devState == 4'h8)[*4]
    ##[1:6] devState == sbpsf_pkg::DEV_NORMAL) else $error("mw length");
endmodule

bind sbpsf_top sbpsf_sva u_sva (.core_clk, .rst, .clkGate, .devState,
  .bankStates, .anyBankActive, .exitWait, .modeWriteLoad, .modeReadReturn);

// >>> tb/sbpsf_ctrl_model.sv
// Purpose: Memory controller model driving commands and the clock gate.
// Assumes: Lines change 1 ns after the rising edge.
// Notes: Deselected cycles invert the bank lines.
`timescale 1ns/100ps
module sbpsf_ctrl_model (
  input wire logic core_clk,
  input wire logic exitWait,
  output logic clkGate,
  output logic chipSel_n,
  output logic [3:0] cmdCode,
  output logic [2:0] cmdBank
);
  logic sawWait; // An exit wait was seen on the last wake.
  // Start deselected with the gate open.
  initial begin
    clkGate = 1'b1;
    chipSel_n = 1'b1;
    cmdCode = sbpsf_pkg::CMD_NOP;
    cmdBank = 3'h0;
    sawWait = 1'b0;
  end
  // Deselected no-op after a command.
  task automatic idle();
    @(posedge core_clk);
    #1;
    chipSel_n = 1'b1;
    cmdCode = sbpsf_pkg::CMD_NOP;
    cmdBank = ~cmdBank;
  endtask
  // One command held two edges, so the pin filter passes it.
  task automatic send(input logic [3:0] c, input logic [2:0] b);
    @(posedge core_clk);
    #1;
    chipSel_n = 1'b0;
    cmdCode = c;
    cmdBank = b;
    @(posedge core_clk);
    idle();
  endtask
  // Gate falls together with the given select and command.
  task automatic sleep(input logic csn, input logic [3:0] c);
    @(posedge core_clk);
    #1;
    clkGate = 1'b0;
    chipSel_n = csn;
    cmdCode = c;
    @(posedge core_clk);
    idle();
  endtask
  // Gate rises deselected; only no-ops follow.
  task automatic wake(input int lim);
    int n;
    n = 0;
    sawWait = 1'b0;
    @(posedge core_clk);
    #1;
    clkGate = 1'b1;
    while (n < lim && !(sawWait && exitWait === 1'b0)) begin
      @(posedge core_clk);
      #1;
      sawWait = sawWait | (exitWait === 1'b1);
      n++;
    end
  endtask
endmodule

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the bank and power state machine.
// Assumes: Init interval shortened to 20 cycles.
// Notes: Tasks poll outputs under a bound.
`timescale 1ns/100ps
module testbench;
  logic core_clk, rst; // Clock and active-high reset.
  logic clkGate, chipSel_n; // Pins from the controller.
  logic [3:0] cmdCode, devState; // Command and device state.
  logic [2:0] cmdBank; // Target bank.
  logic [23:0] bankStates; // All bank states.
  logic anyBankActive, exitWait, modeWriteLoad, modeReadReturn;
  int err_count, check_count, cycCount, mwCount, mrCount;
  sbpsf_top #(.INIT_CYCLES(20)) i_sbpsf_top (.core_clk, .rst, .clkGate,
    .chipSel_n, .cmdCode, .cmdBank, .devState, .bankStates,
    .anyBankActive, .exitWait, .modeWriteLoad, .modeReadReturn);
  sbpsf_ctrl_model ctl (.core_clk, .exitWait, .clkGate, .chipSel_n,
    .cmdCode, .cmdBank);
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  // Count strobes and cycles; a hang ends the run.
  always @(posedge core_clk) begin
    mwCount += int'(modeWriteLoad === 1'b1);
    mrCount += int'(modeReadReturn === 1'b1);
    cycCount++;
    if (cycCount == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Compare one value and report a mismatch.
  task automatic check(input logic [23:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Poll for a device state, then compare.
  task automatic wait_dev(input logic [3:0] st);
    for (int n = 0; n < 60 && devState !== st; n++) begin
      @(posedge core_clk);
      #2;
    end
    check(devState, st);
  endtask
  // Poll for a bank 3 state, then compare.
  task automatic wait_bk(input logic [2:0] st);
    for (int n = 0; n < 60 && bankStates[11:9] !== st; n++) begin
      @(posedge core_clk);
      #2;
    end
    check(bankStates[11:9], st);
  endtask
  // Reset, resetting power-down and its exit.
  task automatic t_init();
    check(devState, sbpsf_pkg::DEV_POWER_ON);
    ctl.send(sbpsf_pkg::CMD_RESET, 3'h0);
    wait_dev(sbpsf_pkg::DEV_RESETTING);
    ctl.sleep(1'b1, sbpsf_pkg::CMD_NOP);
    wait_dev(sbpsf_pkg::DEV_RESET_PD);
    ctl.wake(1);
    wait_dev(sbpsf_pkg::DEV_RESETTING);
    wait_dev(sbpsf_pkg::DEV_NORMAL);
  endtask
  // Row open, bursts and burst terminate.
  task automatic t_rows();
    ctl.send(sbpsf_pkg::CMD_ACTIVATE, 3'h3);
    wait_bk(sbpsf_pkg::BK_ACTIVATING);
    wait_bk(sbpsf_pkg::BK_ACTIVE);
    check(anyBankActive, 1'b1);
    check(bankStates & 24'hfff1ff, 24'h0);
    ctl.send(sbpsf_pkg::CMD_READ, 3'h3);
    wait_bk(sbpsf_pkg::BK_READING);
    ctl.send(sbpsf_pkg::CMD_READ, 3'h3);
    repeat (6) @(posedge core_clk);
    check(bankStates[11:9], sbpsf_pkg::BK_READING);
    ctl.send(sbpsf_pkg::CMD_WRITE, 3'h3);
    wait_bk(sbpsf_pkg::BK_WRITING);
    ctl.send(sbpsf_pkg::CMD_READ, 3'h3);
    wait_bk(sbpsf_pkg::BK_READING);
    ctl.send(sbpsf_pkg::CMD_BURST_TERM, 3'h3);
    wait_bk(sbpsf_pkg::BK_ACTIVE);
    ctl.send(sbpsf_pkg::CMD_WRITE, 3'h3);
    wait_bk(sbpsf_pkg::BK_WRITING);
    ctl.send(sbpsf_pkg::CMD_BURST_TERM, 3'h3);
    wait_bk(sbpsf_pkg::BK_ACTIVE);
  endtask
  // Active and idle power-down around a precharge.
  task automatic t_pdown();
    ctl.sleep(1'b1, sbpsf_pkg::CMD_NOP);
    wait_dev(sbpsf_pkg::DEV_ACTIVE_PD);
    repeat (20) @(posedge core_clk);
    check(devState, sbpsf_pkg::DEV_ACTIVE_PD);
    ctl.wake(40);
    check(ctl.sawWait, 1'b1);
    check(bankStates[11:9], sbpsf_pkg::BK_ACTIVE);
    ctl.send(sbpsf_pkg::CMD_PRECHARGE, 3'h3);
    wait_bk(sbpsf_pkg::BK_PRECHARGING);
    wait_bk(sbpsf_pkg::BK_IDLE);
    check(anyBankActive, 1'b0);
    ctl.sleep(1'b1, sbpsf_pkg::CMD_NOP);
    wait_dev(sbpsf_pkg::DEV_IDLE_PD);
    ctl.wake(40);
    wait_dev(sbpsf_pkg::DEV_NORMAL);
  endtask
  // Mode register access and both refreshes.
  task automatic t_mode_ref();
    ctl.send(sbpsf_pkg::CMD_MODE_WRITE, 3'h0);
    wait_dev(sbpsf_pkg::DEV_MODE_WRITING);
    wait_dev(sbpsf_pkg::DEV_NORMAL);
    check(mwCount, 1);
    ctl.send(sbpsf_pkg::CMD_MODE_READ, 3'h0);
    wait_dev(sbpsf_pkg::DEV_MODE_READING);
    wait_dev(sbpsf_pkg::DEV_NORMAL);
    check(mrCount, 1);
    ctl.send(sbpsf_pkg::CMD_REFRESH_BANK, 3'h3);
    wait_bk(sbpsf_pkg::BK_REFRESHING);
    wait_bk(sbpsf_pkg::BK_IDLE);
    ctl.send(sbpsf_pkg::CMD_REFRESH_ALL, 3'h0);
    wait_dev(sbpsf_pkg::DEV_REFRESH_ALL);
    wait_dev(sbpsf_pkg::DEV_NORMAL);
  endtask
  // Self refresh and deep power-down entry and exit.
  task automatic t_sref_dpd();
    ctl.sleep(1'b0, sbpsf_pkg::CMD_SELF_REFRESH);
    wait_dev(sbpsf_pkg::DEV_SELF_REFRESH);
    repeat (20) @(posedge core_clk);
    check(devState, sbpsf_pkg::DEV_SELF_REFRESH);
    ctl.wake(40);
    check(ctl.sawWait, 1'b1);
    wait_dev(sbpsf_pkg::DEV_NORMAL);
    ctl.sleep(1'b0, sbpsf_pkg::CMD_DEEP_PD);
    wait_dev(sbpsf_pkg::DEV_DEEP_PD);
    ctl.wake(40);
    wait_dev(sbpsf_pkg::DEV_POWER_ON);
    ctl.send(sbpsf_pkg::CMD_RESET, 3'h0);
    wait_dev(sbpsf_pkg::DEV_RESETTING);
    wait_dev(sbpsf_pkg::DEV_NORMAL);
  endtask
  // Reset for 8 cycles, then run every scenario.
  initial begin
    rst = 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    rst = 1'b0;
    repeat (6) @(posedge core_clk);
    t_init();
    t_rows();
    t_pdown();
    t_mode_ref();
    t_sref_dpd();
    print_verdict();
  end
endmodule
